// file: inc/itsc_defs.svh
// Constants for the interval timer status and count port block.
// Assumes inclusion by the package, the design modules and the port checker.
`ifndef ITSC_DEFS_SVH
`define ITSC_DEFS_SVH

// ==========================================================================
// Port decode
`define ITSC_ADDR_W        8
`define ITSC_PORT_T1C0     8'h40
`define ITSC_PORT_T1C1     8'h41
`define ITSC_PORT_T1C2     8'h42
`define ITSC_PORT_T2C0     8'h48
`define ITSC_PORT_T2C2     8'h4a
`define ITSC_NUM_CTR       5

// ==========================================================================
// Status byte fields
`define ITSC_ST_OUT        7
`define ITSC_ST_NULL       6
`define ITSC_ST_RW_HI      5
`define ITSC_ST_RW_LO      4
`define ITSC_ST_MODE_HI    3
`define ITSC_ST_MODE_LO    1
`define ITSC_ST_BCD        0

// ==========================================================================
// Read/write format codes
`define ITSC_RW_LATCH      2'h0
`define ITSC_RW_LSB        2'h1
`define ITSC_RW_MSB        2'h2
`define ITSC_RW_WORD       2'h3

`define ITSC_BYTE_ZERO     8'h00
`define ITSC_WORD_ZERO     16'h0000

`endif

// file: inc/itsc_pkg.sv
// Types shared by the timer port block and its per-counter slice.
// Assumes the defines header sits on the include path.
`include "itsc_defs.svh"

package itsc_pkg;
  typedef logic [7:0]  itsc_byte_t;
  typedef logic [15:0] itsc_word_t;
  typedef logic [1:0]  itsc_rw_t;
  typedef logic [2:0]  itsc_mode_t;
  // Byte pointer for two-byte transfers, low byte first
  typedef enum logic {
    ITSC_PTR_LO = 1'b0,
    ITSC_PTR_HI = 1'b1
  } itsc_ptr_e;
endpackage

// file: hdl/itsc_counter_port.sv
// One counter's byte port: count loading, latched count and status read.
// Assumes the counting element and command decode live outside and pass in
// mode, format, output level, count, latch strobes and load acknowledge.
`timescale 1ns/1ps
`include "itsc_defs.svh"

module itsc_counter_port
  import itsc_pkg::*;
(
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               rst_n,
  // Port access strobes
  input  wire logic               wr_stb,
  input  wire logic               rd_stb,
  input  wire itsc_pkg::itsc_byte_t wdata,
  // Programming and live state
  input  wire itsc_pkg::itsc_rw_t   rw_fmt,
  input  wire itsc_pkg::itsc_mode_t mode,
  input  wire logic               bcd,
  input  wire logic               cw_stb,
  input  wire logic               out_lvl,
  input  wire itsc_pkg::itsc_word_t ce_count,
  input  wire logic               ce_load,
  input  wire logic               latch_cnt,
  input  wire logic               latch_st,
  // Results
  output itsc_pkg::itsc_byte_t      rdata,
  output itsc_pkg::itsc_word_t      hold_q,
  output logic                    hold_wr
);

  // ========================================================================
  // State
  itsc_word_t hold_d;
  logic       null_q;
  itsc_word_t lat_q;
  logic       lat_v_q;
  itsc_byte_t st_q;
  logic       st_v_q;
  itsc_ptr_e  wptr_q;
  itsc_ptr_e  rptr_q;

  // ========================================================================
  // Decode of byte selection
  wire        fmt_word   = (rw_fmt == `ITSC_RW_WORD);
  wire        fmt_msb    = (rw_fmt == `ITSC_RW_MSB);
  wire        wr_hi      = fmt_msb | (fmt_word & (wptr_q == ITSC_PTR_HI));
  wire        wr_done    = wr_stb & (~fmt_word | (wptr_q == ITSC_PTR_HI));
  // [RQ4] Count source is latch while held, else element
  wire itsc_word_t src   = lat_v_q ? lat_q : ce_count;
  wire        rsel_hi    = fmt_msb | (fmt_word & (rptr_q == ITSC_PTR_HI));
  wire itsc_byte_t cnt_b = rsel_hi ? src[15:8] : src[7:0];
  wire        rd_st      = rd_stb & st_v_q;
  wire        rd_cnt     = rd_stb & ~st_v_q;
  wire        cnt_last   = ~fmt_word | (rptr_q == ITSC_PTR_HI);
  // [RQ2] Status byte assembly
  wire itsc_byte_t st_d  = {out_lvl, null_q, rw_fmt, mode, bcd};

  // [RQ8] Holding register byte order
  always_comb begin
    hold_d = hold_q;
    if (wr_stb & wr_hi) begin
      hold_d[15:8] = wdata;
      if (fmt_msb) hold_d[7:0] = `ITSC_BYTE_ZERO;
    end else if (wr_stb) begin
      hold_d[7:0] = wdata;
      if (~fmt_word) hold_d[15:8] = `ITSC_BYTE_ZERO;
    end
  end

  // Write side and null count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_q  <= `ITSC_WORD_ZERO;
      hold_wr <= 1'b0;
      wptr_q  <= ITSC_PTR_LO;
      null_q  <= 1'b0;
    end else begin
      hold_q  <= hold_d;
      hold_wr <= wr_done;
      if (cw_stb) wptr_q <= ITSC_PTR_LO;
      else if (wr_stb & fmt_word) wptr_q <= itsc_ptr_e'(~wptr_q);
      // [RQ3] New count pends until load
      if (wr_done | cw_stb) null_q <= 1'b1;
      else if (ce_load) null_q <= 1'b0;
    end
  end

  // Latches and read pointer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lat_q   <= `ITSC_WORD_ZERO;
      lat_v_q <= 1'b0;
      st_q    <= `ITSC_BYTE_ZERO;
      st_v_q  <= 1'b0;
      rptr_q  <= ITSC_PTR_LO;
    end else begin
      // [RQ11] Second latch ignored
      if (latch_cnt & ~lat_v_q) begin
        lat_q   <= ce_count;
        lat_v_q <= 1'b1;
      end else if (rd_cnt & cnt_last) begin
        lat_v_q <= 1'b0;
      end
      // [RQ1] Status held for next read
      if (latch_st & ~st_v_q) begin
        st_q   <= st_d;
        st_v_q <= 1'b1;
      end else if (rd_st) begin
        st_v_q <= 1'b0;
      end
      if (cw_stb) rptr_q <= ITSC_PTR_LO;
      else if (rd_cnt & fmt_word) rptr_q <= itsc_ptr_e'(~rptr_q);
    end
  end

  // [RQ13] Status before count
  // [RQ9] Read data selection
  assign rdata = st_v_q ? st_q : cnt_b;

endmodule

// file: hdl/itsc_ports.sv
// Host I/O byte ports of five interval timer counters.
// Assumes single-cycle I/O strobes synchronous to CLK_SYS; the command
// decoder and counting elements sit outside and exchange per-counter vectors.
`timescale 1ns/1ps
`include "itsc_defs.svh"

// Behaviour
// [RQ1] Status latch returns status next read
// [RQ2] Bit 7 is output pin level
// [RQ3] Bit 6 set until count loaded
// [RQ4] Reads before load give element count
// [RQ5] Bits 5:4 give programmed byte format
// [RQ6] Bits 3:1 give programmed mode
// [RQ7] Bit 0 set for BCD counting
// [RQ8] Count written in programmed byte order
// [RQ9] Reads give count, latch or status
// [RQ10] Ports at 40h-42h, 48h, 4Ah
// [RQ11] Relatch before read is ignored
// [RQ12] Software reads both latched bytes
// [RQ13] Status first, then latched count
module itsc_ports
  import itsc_pkg::*;
#(
  parameter int NCTR = `ITSC_NUM_CTR
)(
  // Clock and reset
  input  wire logic                       CLK_SYS,
  input  wire logic                       RSTN,
  // Host I/O access
  input  wire logic [`ITSC_ADDR_W-1:0]    IO_ADDR,
  input  wire logic                       IO_WR,
  input  wire logic                       IO_RD,
  input  wire itsc_pkg::itsc_byte_t         IO_WDATA,
  output itsc_pkg::itsc_byte_t              IO_RDATA,
  output logic                            IO_HIT,
  // Programming from command decode, per counter
  input  wire logic [2*NCTR-1:0]          CTR_RW_FMT,
  input  wire logic [3*NCTR-1:0]          CTR_MODE,
  input  wire logic [NCTR-1:0]            CTR_BCD,
  input  wire logic [NCTR-1:0]            CTR_CW_STB,
  input  wire logic [NCTR-1:0]            CTR_LATCH_CNT,
  input  wire logic [NCTR-1:0]            CTR_LATCH_ST,
  // Counting element side
  input  wire logic [NCTR-1:0]            CTR_OUT,
  input  wire logic [16*NCTR-1:0]         CTR_CE_COUNT,
  input  wire logic [NCTR-1:0]            CTR_CE_LOAD,
  output logic [16*NCTR-1:0]              CTR_HOLD,
  output logic [NCTR-1:0]                 CTR_HOLD_WR
);

  // Decode serves exactly five counters; any other count is refused
  if (NCTR != `ITSC_NUM_CTR) begin : g_bad_nctr
    $error("NCTR must match port map");
  end

  // ========================================================================
  // Address decode
  // [RQ10] Fixed port map
  function automatic logic [NCTR-1:0] port_sel(input logic [7:0] a);
    port_sel = '0;
    if (a == `ITSC_PORT_T1C0) port_sel[0] = 1'b1;
    else if (a == `ITSC_PORT_T1C1) port_sel[1] = 1'b1;
    else if (a == `ITSC_PORT_T1C2) port_sel[2] = 1'b1;
    else if (a == `ITSC_PORT_T2C0) port_sel[3] = 1'b1;
    else if (a == `ITSC_PORT_T2C2) port_sel[4] = 1'b1;
  endfunction

  wire logic [NCTR-1:0] sel = port_sel(IO_ADDR);
  itsc_byte_t           rd_vec [NCTR];
  logic [16*NCTR-1:0]   hold_vec;
  logic [NCTR-1:0]      hwr_vec;

  // ========================================================================
  // Counter slices
  for (genvar i = 0; i < NCTR; i++) begin : g_ctr
    itsc_counter_port u_port (
      .clk       (CLK_SYS),
      .rst_n     (RSTN),
      .wr_stb    (IO_WR & sel[i]),
      .rd_stb    (IO_RD & sel[i]),
      .wdata     (IO_WDATA),
      // [RQ5] Format code echoed
      .rw_fmt    (CTR_RW_FMT[2*i +: 2]),
      // [RQ6] Mode code echoed
      .mode      (CTR_MODE[3*i +: 3]),
      // [RQ7] Countdown type echoed
      .bcd       (CTR_BCD[i]),
      .cw_stb    (CTR_CW_STB[i]),
      .out_lvl   (CTR_OUT[i]),
      .ce_count  (CTR_CE_COUNT[16*i +: 16]),
      .ce_load   (CTR_CE_LOAD[i]),
      .latch_cnt (CTR_LATCH_CNT[i]),
      .latch_st  (CTR_LATCH_ST[i]),
      .rdata     (rd_vec[i]),
      .hold_q    (hold_vec[16*i +: 16]),
      .hold_wr   (hwr_vec[i])
    );
  end

  // Read mux, one-hot select
  itsc_byte_t rd_mux;
  always_comb begin
    rd_mux = `ITSC_BYTE_ZERO;
    for (int k = 0; k < NCTR; k++) begin
      if (sel[k]) rd_mux = rd_vec[k];
    end
  end

  // Registered read data; sampled on the read strobe, shown next cycle
  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      IO_RDATA <= `ITSC_BYTE_ZERO;
      IO_HIT   <= 1'b0;
    end else begin
      IO_RDATA <= IO_RD ? rd_mux : `ITSC_BYTE_ZERO;
      IO_HIT   <= (IO_RD | IO_WR) & (|sel);
    end
  end

  // Holding registers straight from slice flops
  assign CTR_HOLD    = hold_vec;
  assign CTR_HOLD_WR = hwr_vec;

endmodule

// file: testbench/itsc_ports_checker.sv
// Port timing checks for the timer byte port block.
// Assumes single-cycle host strobes and registered answers.
`timescale 1ns/1ps
`include "itsc_defs.svh"

module itsc_ports_checker
  import itsc_pkg::*;
#(
  parameter int NCTR = 5
)(
  // Clock and reset
  input logic                 CLK_SYS,
  input logic                 RSTN,
  // Host access
  input logic [7:0]           IO_ADDR,
  input logic                 IO_WR,
  input logic                 IO_RD,
  input itsc_pkg::itsc_byte_t IO_RDATA,
  input logic                 IO_HIT,
  // Holding registers
  input logic [16*NCTR-1:0]   CTR_HOLD,
  input logic [NCTR-1:0]      CTR_HOLD_WR
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RSTN);
  // Decode of the five counter ports
  wire map_w = IO_ADDR inside {[8'h40:8'h42], 8'h48, 8'h4a};
  wire acc_w = IO_RD | IO_WR;

  AST_HIT_MAP: assert property (acc_w && map_w |=> IO_HIT)
    else $error("mapped access gave no hit");
  AST_NO_HIT: assert property (acc_w && !map_w |=> !IO_HIT)
    else $error("unmapped access gave a hit");
  AST_HIT_CAUSE: assert property (IO_HIT |-> $past(acc_w && map_w))
    else $error("hit without mapped access");
  AST_RD_IDLE: assert property (!IO_RD |=> IO_RDATA == 8'h00)
    else $error("read data without a read");
  AST_HWR_CAUSE: assert property (|CTR_HOLD_WR |-> $past(IO_WR))
    else $error("hold strobe without a write");
  AST_HWR_ONE: assert property ($onehot0(CTR_HOLD_WR))
    else $error("several hold strobes at once");
  AST_HOLD_STABLE: assert property (!IO_WR |=> $stable(CTR_HOLD))
    else $error("holding register moved without a write");
  AST_RD_NO_HWR: assert property (IO_RD |=> CTR_HOLD_WR == '0)
    else $error("read loaded a holding register");

  // Main scenarios reached
  cover property (IO_RD && map_w ##1 IO_RDATA != 8'h00);
  cover property (|CTR_HOLD_WR);
  cover property (acc_w && !map_w);
endmodule

bind itsc_ports itsc_ports_checker #(.NCTR(NCTR)) u_itsc_ports_checker (.*);

// file: testbench/itsc_host.sv
// Host processor model issuing byte I/O cycles.
// Assumes answers arrive one cycle after the strobe edge.
`timescale 1ns/1ps

module itsc_host (
  // Clock
  input  logic       clk,
  // Request side
  output logic [7:0] addr,
  output logic       wr,
  output logic       rd,
  output logic [7:0] wdata,
  // Answer side
  input  logic [7:0] rdata
);
  // Idle bus shows an unmapped address
  initial begin
    addr  = 8'hff;
    wr    = 1'b0;
    rd    = 1'b0;
    wdata = 8'h00;
  end
  task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
    addr  <= ~a;
    wdata <= ~d;
    #1;
  endtask
  // Read pops state, so one strobe per byte
  task automatic rd_byte(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    addr <= ~a;
    #1;
    d = rdata;
  endtask
endmodule

// file: testbench/tb_itsc_ports.sv
// Testbench for the timer byte port block.
// Assumes the host model and checker are compiled before it.
`timescale 1ns/1ps

module tb_itsc_ports;
  import itsc_pkg::*;
  // ==========================================================
  // Signals
  logic             clk, rstn, wr, rd, hit;
  logic [7:0]       addr, wdata;
  itsc_byte_t       rdata;
  logic [4:0]       bcd, cws, lcn, lst, out, ld, hwr;
  logic [9:0]       fmt;
  logic [14:0]      mode;
  logic [79:0]      ce, hold;
  int               fails, checks;
  logic [7:0]       pa [5] = '{8'h40, 8'h41, 8'h42, 8'h48, 8'h4a};

  itsc_ports #(.NCTR(5)) u_itsc_ports (
    .CLK_SYS(clk), .RSTN(rstn), .IO_ADDR(addr), .IO_WR(wr),
    .IO_RD(rd), .IO_WDATA(wdata), .IO_RDATA(rdata), .IO_HIT(hit),
    .CTR_RW_FMT(fmt), .CTR_MODE(mode), .CTR_BCD(bcd),
    .CTR_CW_STB(cws), .CTR_LATCH_CNT(lcn), .CTR_LATCH_ST(lst),
    .CTR_OUT(out), .CTR_CE_COUNT(ce), .CTR_CE_LOAD(ld),
    .CTR_HOLD(hold), .CTR_HOLD_WR(hwr));
  itsc_host u_itsc_host (.clk(clk), .addr(addr), .wr(wr), .rd(rd),
    .wdata(wdata), .rdata(rdata));

  // ==========================================================
  // Helpers
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checks++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %0t seen %h exp %h", $time, s, e);
    end
  endtask
  // Both bytes of a two-byte count, low first
  task automatic rd16(input logic [7:0] a, output logic [15:0] w);
    u_itsc_host.rd_byte(a, w[7:0]);
    u_itsc_host.rd_byte(a, w[15:8]);
  endtask
  task automatic st_null(input logic [7:0] a, input logic [4:0] m,
                         input logic e);
    logic [7:0] v;
    @(posedge clk);
    lst <= m;
    @(posedge clk);
    lst <= 5'h00;
    u_itsc_host.rd_byte(a, v);
    chk(16'(v[6]), 16'(e));
  endtask
  task automatic tally_and_finish();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  // Output level flips after the latch to prove it was captured
  task automatic t_status();
    logic [7:0] v;
    for (int k = 0; k < 5; k++) begin
      @(posedge clk);
      fmt[2*k+:2]  <= 2'(k % 3 + 1);
      mode[3*k+:3] <= 3'(k);
      bcd[k]       <= k[0];
      out[k]       <= ~k[0];
      lst          <= 5'(1 << k);
      @(posedge clk);
      lst    <= 5'h00;
      out[k] <= k[0];
      u_itsc_host.rd_byte(pa[k], v);
      chk(16'(v), 16'({~k[0], 1'b0, 2'(k % 3 + 1), 3'(k), k[0]}));
      chk(16'(hit), 16'h0001);
    end
    u_itsc_host.wr_byte(8'h43, 8'h99);
    u_itsc_host.rd_byte(8'h43, v);
    chk(16'(v), 16'h0000);
    chk(16'(hit), 16'h0000);
  endtask
  task automatic t_word();
    logic [15:0] w;
    @(posedge clk);
    fmt[3:2]  <= 2'h3;
    cws       <= 5'h02;
    ce[31:16] <= 16'h4321;
    @(posedge clk);
    cws <= 5'h00;
    ld  <= 5'h02;
    @(posedge clk);
    ld <= 5'h00;
    u_itsc_host.wr_byte(8'h41, 8'hcd);
    u_itsc_host.wr_byte(8'h41, 8'hab);
    chk(hold[31:16], 16'habcd);
    chk(16'(hwr), 16'h0002);
    st_null(8'h41, 5'h02, 1'b1);
    rd16(8'h41, w);
    chk(w, 16'h4321);
    @(posedge clk);
    ld <= 5'h02;
    @(posedge clk);
    ld <= 5'h00;
    st_null(8'h41, 5'h02, 1'b0);
  endtask
  // Second count latch must not overwrite the first
  task automatic t_latch();
    logic [15:0] w;
    @(posedge clk);
    fmt[1:0] <= 2'h3;
    cws      <= 5'h01;
    ce[15:0] <= 16'h1234;
    lcn      <= 5'h01;
    @(posedge clk);
    cws      <= 5'h00;
    ce[15:0] <= 16'h5678;
    lst      <= 5'h01;
    @(posedge clk);
    lcn <= 5'h00;
    lst <= 5'h00;
    u_itsc_host.rd_byte(8'h40, w[7:0]);
    chk(w[7:0], 16'h0070);
    rd16(8'h40, w);
    chk(w, 16'h1234);
    rd16(8'h40, w);
    chk(w, 16'h5678);
  endtask
  // Single-byte formats on counter 2: MSB only, then LSB only
  task automatic t_byte();
    logic [7:0] v;
    for (int f = 2; f >= 1; f--) begin
      @(posedge clk);
      fmt[5:4]  <= 2'(f);
      cws       <= 5'h04;
      ce[47:32] <= 16'h9a3c;
      @(posedge clk);
      cws <= 5'h00;
      u_itsc_host.wr_byte(8'h42, 8'h5a);
      chk(hold[47:32], (f == 2) ? 16'h5a00 : 16'h005a);
      u_itsc_host.rd_byte(8'h42, v);
      chk(16'(v), (f == 2) ? 16'h009a : 16'h003c);
    end
  endtask

  // ==========================================================
  // Clock, reset, sequence and watchdog
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    {rstn, fmt, mode, bcd, cws, lcn, lst, out, ld, ce} = '0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    t_status();
    t_word();
    t_latch();
    t_byte();
    tally_and_finish();
  end
  // Whole run is under a hundred cycles; 5000 cycles is ample margin
  initial begin
    #20000;
    fails++;
    tally_and_finish();
  end
endmodule
